/* File: pkg/phw_pkg.sv */
package phw_pkg;

	// host address width and alignment (bits n:0 reserved)
	localparam int unsigned HOST_ADDRESS_WIDTH = 48;
	localparam int unsigned ALIGN_N            = 11;

	localparam logic [11:0] BASE_LO_OFS   = 12'h070;
	localparam logic [11:0] BASE_HI_OFS   = 12'h074;
	localparam logic [11:0] LIMIT_LO_OFS  = 12'h078;
	localparam logic [11:0] LIMIT_HI_OFS  = 12'h07C;
	localparam logic [11:0] CTRL_OFS      = 12'h100;
	localparam logic [11:0] STATUS_OFS    = 12'h104;

	localparam int unsigned CTRL_SUPPORTED_BIT = 0;
	localparam int unsigned CTRL_ENABLE_BIT    = 1;
	localparam int unsigned STAT_VALID_BIT     = 0;
	localparam int unsigned STAT_ACTIVE_BIT    = 1;
	localparam int unsigned STAT_BLOCKED_BIT   = 2;

	localparam logic [63:0] WINDOW_RESET   = 64'h0000_0000_0000_0000;
	localparam logic [1:0]  CTRL_RESET     = 2'h1;
	localparam logic [1:0]  RESP_OKAY      = 2'h0;
	localparam logic [1:0]  RESP_SLVERR    = 2'h2;

	// implemented bits: host_address_width-1 down to n+1
	localparam logic [63:0] IMPL_MASK =
		((64'h1 << HOST_ADDRESS_WIDTH) - 64'h1) &
		~((64'h1 << (ALIGN_N + 1)) - 64'h1);
	localparam logic [63:0] LOW_ONES = (64'h1 << (ALIGN_N + 1)) - 64'h1;

	typedef struct packed {
		logic        valid;
		logic [63:0] addr;
	} phw_dma_req_t;

	typedef struct packed {
		logic valid;
		logic block;
	} phw_dma_rsp_t;

endpackage

/* File: hw/phw_window.sv */
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Operation
// - unsupported window makes both registers read-only
// - base low bits read zero, decode zero
// - limit low bits decode as all ones
// - writes of ones read back zero low
// - equal upper bits give 2^(N+1) window
// - limit below base disables window
// - bits above host width unimplemented, ignored
// - window may sit anywhere in address space
// - limit is last address, inclusive
// - base field writable, resets to zero
module phw_window
	import phw_pkg::*;
(
	input  wire logic         clock,
	input  wire logic         rstn,
	input  wire logic [11:0]  s_axi_awaddr,
	input  wire logic         s_axi_awvalid,
	output logic              s_axi_awready,
	input  wire logic [31:0]  s_axi_wdata,
	input  wire logic [3:0]   s_axi_wstrb,
	input  wire logic         s_axi_wvalid,
	output logic              s_axi_wready,
	output logic [1:0]        s_axi_bresp,
	output logic              s_axi_bvalid,
	input  wire logic         s_axi_bready,
	input  wire logic [11:0]  s_axi_araddr,
	input  wire logic         s_axi_arvalid,
	output logic              s_axi_arready,
	output logic [31:0]       s_axi_rdata,
	output logic [1:0]        s_axi_rresp,
	output logic              s_axi_rvalid,
	input  wire logic         s_axi_rready,
	input  wire phw_dma_req_t dma_req,
	output phw_dma_rsp_t      dma_rsp
);

	logic [63:0] base_q;
	logic [63:0] limit_q;
	logic [1:0]  ctrl_q;
	logic        aw_full_q;
	logic [11:0] aw_addr_q;
	logic        w_full_q;
	logic [31:0] w_data_q;
	logic [3:0]  w_strb_q;
	logic        bvalid_q;
	logic [1:0]  bresp_q;
	logic        rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0]  rresp_q;
	phw_dma_rsp_t dma_rsp_q;

	logic        wr_go;
	logic        window_valid;
	logic        protect_on;
	logic [63:0] dec_base;
	logic [63:0] dec_limit;
	logic        hit;
	logic [32:0] aw_word;
	logic [32:0] ar_word;

	// merge a 32-bit lane write into one half of a 64-bit register
	function automatic logic [63:0] merge_half(
		input logic [63:0] old,
		input logic        hi,
		input logic [31:0] data,
		input logic [3:0]  strb
	);
		logic [63:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[(hi ? 32 : 0) + 8*i +: 8] = data[8*i +: 8];
			end
		end
		return res & IMPL_MASK;
	endfunction

	// read value of any mapped offset; valid flag cleared if unmapped
	function automatic logic [32:0] read_word(input logic [11:0] a);
		logic [32:0] r;
		r = 33'h0_0000_0000;
		if (a == BASE_LO_OFS) begin
			r = {1'b1, base_q[31:0]};
		end else if (a == BASE_HI_OFS) begin
			r = {1'b1, base_q[63:32]};
		end else if (a == LIMIT_LO_OFS) begin
			r = {1'b1, limit_q[31:0]};
		end else if (a == LIMIT_HI_OFS) begin
			r = {1'b1, limit_q[63:32]};
		end else if (a == CTRL_OFS) begin
			r = {1'b1, 30'h0, ctrl_q};
		end else if (a == STATUS_OFS) begin
			r = {1'b1, 29'h0, dma_rsp_q.block, protect_on,
				window_valid};
		end
		return r;
	endfunction

	// decode once per channel; a call result cannot be bit-selected
	assign aw_word = read_word(aw_addr_q);
	assign ar_word = read_word({s_axi_araddr[11:2], 2'h0});

	// write channel: address and data latched independently
	assign s_axi_awready = !aw_full_q;
	assign s_axi_wready  = !w_full_q;
	assign wr_go = aw_full_q && w_full_q && !bvalid_q;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			aw_full_q <= 1'b0;
			aw_addr_q <= 12'h000;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_full_q <= 1'b1;
			aw_addr_q <= {s_axi_awaddr[11:2], 2'h0};
		end else if (wr_go) begin
			aw_full_q <= 1'b0;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			w_full_q <= 1'b0;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_full_q <= 1'b1;
			w_data_q <= s_axi_wdata;
			w_strb_q <= s_axi_wstrb;
		end else if (wr_go) begin
			w_full_q <= 1'b0;
		end
	end

	// window registers; locked while unsupported, reset to zero
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			base_q  <= WINDOW_RESET;
			limit_q <= WINDOW_RESET;
		end else if (wr_go && ctrl_q[CTRL_SUPPORTED_BIT]) begin
			// no lock on enable: software is trusted to not touch them
			if (aw_addr_q == BASE_LO_OFS || aw_addr_q == BASE_HI_OFS) begin
				base_q <= merge_half(base_q, aw_addr_q[2], w_data_q,
					w_strb_q);
			end else if (aw_addr_q == LIMIT_LO_OFS ||
					aw_addr_q == LIMIT_HI_OFS) begin
				limit_q <= merge_half(limit_q, aw_addr_q[2], w_data_q,
					w_strb_q);
			end
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			ctrl_q <= CTRL_RESET;
		end else if (wr_go && aw_addr_q == CTRL_OFS && w_strb_q[0]) begin
			ctrl_q <= w_data_q[1:0];
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			bvalid_q <= 1'b0;
			bresp_q  <= RESP_OKAY;
		end else if (wr_go) begin
			bvalid_q <= 1'b1;
			bresp_q  <= aw_word[32] ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end

	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp  = bresp_q;

	// read channel: one outstanding read, answered the next cycle
	assign s_axi_arready = !rvalid_q;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h0000_0000;
			rresp_q  <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_q <= 1'b1;
			rdata_q  <= ar_word[31:0];
			rresp_q  <= ar_word[32] ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata  = rdata_q;
	assign s_axi_rresp  = rresp_q;

	// decoding: full 64-bit compare, so any placement works
	assign dec_base  = base_q & IMPL_MASK;
	assign dec_limit = (limit_q & IMPL_MASK) | LOW_ONES;
	assign window_valid = (limit_q & IMPL_MASK) >= dec_base;
	assign protect_on = ctrl_q[CTRL_ENABLE_BIT] &&
		ctrl_q[CTRL_SUPPORTED_BIT];
	// address bits above host width ignored
	assign hit = ((dma_req.addr & ((64'h1 << HOST_ADDRESS_WIDTH) - 64'h1))
		>= dec_base) &&
		((dma_req.addr & ((64'h1 << HOST_ADDRESS_WIDTH) - 64'h1))
		<= dec_limit);

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			dma_rsp_q <= '0;
		end else begin
			dma_rsp_q.valid <= dma_req.valid;
			dma_rsp_q.block <= dma_req.valid && protect_on &&
				window_valid && hit;
		end
	end

	assign dma_rsp = dma_rsp_q;

endmodule // phw_window

/* File: test/phw_window_properties.sv */
`timescale 1ns/1ps
module phw_window_properties
	import phw_pkg::*;
(
	input wire logic         clock,
	input wire logic         rstn,
	input wire logic         s_axi_awvalid,
	input wire logic         s_axi_awready,
	input wire logic         s_axi_wvalid,
	input wire logic         s_axi_wready,
	input wire logic         s_axi_bvalid,
	input wire logic         s_axi_bready,
	input wire logic [11:0]  s_axi_araddr,
	input wire logic         s_axi_arvalid,
	input wire logic         s_axi_arready,
	input wire logic [31:0]  s_axi_rdata,
	input wire logic         s_axi_rvalid,
	input wire logic         s_axi_rready,
	input wire phw_dma_req_t dma_req,
	input wire phw_dma_rsp_t dma_rsp
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	logic rd_go;
	assign rd_go = s_axi_arvalid && s_axi_arready;
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write answer dropped early");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
		else $error("read answer dropped early");
	a_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answer pending");
	a_b_answer: assert property (s_axi_awvalid && s_axi_awready &&
		s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write answer late");
	a_base_low: assert property (rd_go && s_axi_araddr == BASE_LO_OFS
		|=> s_axi_rvalid && s_axi_rdata[11:0] == 12'h000)
		else $error("base low bits not zero");
	a_limit_low: assert property (rd_go && s_axi_araddr == LIMIT_LO_OFS
		|=> s_axi_rvalid && s_axi_rdata[11:0] == 12'h000)
		else $error("limit low bits not zero");
	a_high_unimpl: assert property (rd_go && s_axi_araddr == BASE_HI_OFS
		|=> s_axi_rvalid && s_axi_rdata[31:16] == 16'h0000)
		else $error("bits above host width read back");
	a_idle_pass: assert property (!dma_req.valid |=> !dma_rsp.block)
		else $error("idle lookup blocked");
	a_rsp_next: assert property (dma_req.valid |=> dma_rsp.valid)
		else $error("lookup answer missing");
	cover property (dma_rsp.block);
	cover property (s_axi_bvalid && s_axi_bready);
	cover property (s_axi_rvalid && s_axi_rready);
endmodule // phw_window_properties

bind phw_window phw_window_properties u_props (.*);

/* File: test/protected_high_mem_region_bench.sv */
`timescale 1ns/1ps
module protected_high_mem_region_bench;
	import phw_pkg::*;
	logic         clock, rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic         s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
	logic         s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [11:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0]  s_axi_wdata, s_axi_rdata, got;
	logic [3:0]   s_axi_wstrb;
	logic [1:0]   s_axi_bresp, s_axi_rresp, resp;
	logic [75:0]  rows [4];
	phw_dma_req_t dma_req;
	phw_dma_rsp_t dma_rsp;
	int           mismatches, checks_done;
	phw_window dut (.*);
	task automatic stop_test;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			mismatches++;
			$display("ERROR %0t got %h want %h", $time, g, e);
		end
	endtask
	task automatic hang;
		mismatches++;
		$display("ERROR %0t no answer", $time);
		stop_test;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clock);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		repeat (50) begin
			@(posedge clock);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) begin
				resp = s_axi_bresp;
				s_axi_bready <= 1'b0;
				return;
			end
		end
		hang;
	endtask
	task automatic rd(input logic [11:0] a);
		@(posedge clock);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		repeat (50) begin
			@(posedge clock);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) begin
				got = s_axi_rdata;
				s_axi_rready <= 1'b0;
				return;
			end
		end
		hang;
	endtask
	// answer is registered: look two edges after the request lands
	task automatic dm(input logic [63:0] a, input logic e);
		@(posedge clock);
		dma_req <= '{1'b1, a};
		repeat (2) @(posedge clock);
		chk({31'h0, dma_rsp.block}, {31'h0, e});
	endtask
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	initial begin
		rstn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
		{s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hF;
		dma_req = '0;
		rows = '{{BASE_LO_OFS, 32'hFFFF_FFFF, 32'hFFFF_F000},
			{BASE_HI_OFS, 32'hFFFF_FFFF, 32'h0000_FFFF},
			{LIMIT_LO_OFS, 32'hFFFF_FFFF, 32'hFFFF_F000},
			{LIMIT_HI_OFS, 32'hFFFF_FFFF, 32'h0000_FFFF}};
		repeat (20) @(posedge clock);
		rstn <= 1'b1;
		rd(BASE_LO_OFS);
		chk(got, 32'h0);
		$display("reset test done");
		foreach (rows[i]) begin
			wr(rows[i][75:64], rows[i][63:32]);
			rd(rows[i][75:64]);
			chk(got, rows[i][31:0]);
		end
		$display("row tests done");
		// limit low written zero still decodes as all ones
		wr(BASE_LO_OFS, 32'h0);
		wr(BASE_HI_OFS, 32'h1);
		wr(LIMIT_LO_OFS, 32'h0);
		wr(LIMIT_HI_OFS, 32'h1);
		wr(CTRL_OFS, 32'h3);
		dm(64'h1_0000_0000, 1'b1);
		dm(64'h1_0000_0FFF, 1'b1);
		dm(64'h1_0000_1000, 1'b0);
		dm(64'h0_FFFF_FFFF, 1'b0);
		wr(CTRL_OFS, 32'h1);
		wr(LIMIT_HI_OFS, 32'h0);
		wr(CTRL_OFS, 32'h3);
		dm(64'h1_0000_0000, 1'b0);
		$display("window test done");
		wr(CTRL_OFS, 32'h0);
		wr(BASE_HI_OFS, 32'h5);
		rd(BASE_HI_OFS);
		chk(got, 32'h1);
		wr(12'h0F0, 32'h1);
		chk({30'h0, resp}, {30'h0, RESP_SLVERR});
		$display("read-only test done");
		stop_test;
	end
endmodule // protected_high_mem_region_bench
